// ==== logic/kli_pkg.sv ====
package kli_pkg;

   // ----------------------------------------------------------------
   // geometry and reset values
   // ----------------------------------------------------------------
   localparam int         LINES      = 8;
   localparam int         STAT_WIDTH = 2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] PORT_IDLE  = 8'hFF;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_LEVEL_SEL  = 8'h9C;
   localparam logic [7:0] ADDR_LINE_EN    = 8'h9D;
   localparam logic [7:0] ADDR_LINE_FLAGS = 8'h9E;
   localparam logic [7:0] ADDR_CTRL       = 8'hA0;
   localparam logic [7:0] ADDR_STATUS     = 8'hA1;
   localparam logic [7:0] ADDR_MASK       = 8'hA2;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_GLOBAL_BIT = 0;
   localparam int STAT_KEY_BIT    = 0;
   localparam int STAT_WAKE_BIT   = 1;

   // ----------------------------------------------------------------
   // register select decode
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_LEVEL,
      SEL_ENABLE,
      SEL_FLAGS,
      SEL_CTRL,
      SEL_STATUS,
      SEL_MASK
   } kli_sel_t;

   function automatic kli_sel_t decodeAddr(input logic [7:0] addr);
      case (addr)
         ADDR_LEVEL_SEL:  decodeAddr = SEL_LEVEL;
         ADDR_LINE_EN:    decodeAddr = SEL_ENABLE;
         ADDR_LINE_FLAGS: decodeAddr = SEL_FLAGS;
         ADDR_CTRL:       decodeAddr = SEL_CTRL;
         ADDR_STATUS:     decodeAddr = SEL_STATUS;
         ADDR_MASK:       decodeAddr = SEL_MASK;
         default:         decodeAddr = SEL_NONE;
      endcase
   endfunction

endpackage

// ==== logic/kli_sync3.sv ====
`timescale 1ns/1ps
module kli_sync3 #(
   parameter int               WIDTH     = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // pins in, filtered level out
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] level_d;

   // ----------------------------------------------------------------
   // accept a bit once stages two and three agree
   // ----------------------------------------------------------------
   always_comb begin
      level_d = level_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (stage2_q[i] == stage3_q[i]) begin
            level_d[i] = stage3_q[i];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         stage1_q <= RESET_VAL;
         stage2_q <= RESET_VAL;
         stage3_q <= RESET_VAL;
         level_q  <= RESET_VAL;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         level_q  <= level_d;
      end
   end

   assign syncOut = level_q;

endmodule

// ==== logic/kli_flag_bank.sv ====
`timescale 1ns/1ps
module kli_flag_bank #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // set per line, clear all
   input  wire logic [WIDTH-1:0] setV,
   input  wire logic             clrAll,
   output logic      [WIDTH-1:0] flags
);

   logic [WIDTH-1:0] flag_q;
   logic [WIDTH-1:0] flag_d;

   // ----------------------------------------------------------------
   // sticky flags, a set beats a clear in the same cycle
   // ----------------------------------------------------------------
   for (genvar i = 0; i < WIDTH; i++) begin : gLine
      always_comb begin
         flag_d[i] = (flag_q[i] & ~clrAll) | setV[i];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flags = flag_q;

endmodule

// ==== logic/kli_keypad_lines.sv ====
// Summary of operation
// - each of lines 0 to 7 sets its own flag on its programmed level
// - a set flag requests the keypad interrupt only while its enable is one
// - flags are sticky; only a flag register read or reset clears them
// - software writes to the flag register are ignored
// - reading the flag register returns the flags, then clears all eight except lines still at their level in that cycle
// - enable zero leaves the pin as plain I/O with no interrupt request
// - enable one lets the line flag drive an interrupt request
// - reset clears all flags and all enable bits
// - level select zero detects low, one detects high, per line
// - all lines share one request, gated by a global enable bit
// - enabled keypad flags raise a wake request for idle and power-down
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module kli_keypad_lines (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrStb,
   input  wire logic       regRdStb,
   output logic      [7:0] regRdData,
   // keypad port lines
   input  wire logic [7:0] portIn,
   output logic      [7:0] keyLineEn,
   // requests
   output logic            keyIrqReq,
   output logic            wakeReq,
   output logic            irq
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   localparam int N = kli_pkg::LINES;
   localparam int S = kli_pkg::STAT_WIDTH;

   logic [N-1:0]     lineLvl;
   logic [N-1:0]     hitV;
   logic [N-1:0]     flagsV;
   logic             rdFlags;
   kli_pkg::kli_sel_t wrSel;
   kli_pkg::kli_sel_t rdSel;

   logic [N-1:0]     levelSel_q;
   logic [N-1:0]     levelSel_d;
   logic [N-1:0]     lineEn_q;
   logic [N-1:0]     lineEn_d;
   logic             globalEn_q;
   logic             globalEn_d;
   logic [S-1:0]     status_q;
   logic [S-1:0]     status_d;
   logic [S-1:0]     mask_q;
   logic [S-1:0]     mask_d;
   logic [S-1:0]     statEvt;

   logic [7:0]       rdData_q;
   logic [7:0]       rdData_d;
   logic             keyIrq_q;
   logic             keyIrq_d;
   logic             wake_q;
   logic             wake_d;
   logic             irq_q;
   logic             irq_d;
   logic             wasReset_q;

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   kli_sync3 #(
      .WIDTH     (N),
      .RESET_VAL (kli_pkg::PORT_IDLE)
   ) uSync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .asyncIn  (portIn),
      .syncOut  (lineLvl)
   );

   // ----------------------------------------------------------------
   // level detection and flags
   // ----------------------------------------------------------------
   // level compare
   assign hitV = ~(lineLvl ^ levelSel_q);

   assign wrSel   = regWrStb ? kli_pkg::decodeAddr(regAddr) : kli_pkg::SEL_NONE;
   assign rdSel   = regRdStb ? kli_pkg::decodeAddr(regAddr) : kli_pkg::SEL_NONE;
   assign rdFlags = (rdSel == kli_pkg::SEL_FLAGS);

   kli_flag_bank #(
      .WIDTH (N)
   ) uFlags (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .setV     (hitV),
      .clrAll   (rdFlags),
      .flags    (flagsV)
   );

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_comb begin
      levelSel_d = levelSel_q;
      lineEn_d   = lineEn_q;
      globalEn_d = globalEn_q;
      mask_d     = mask_q;
      statEvt    = '0;
      statEvt[kli_pkg::STAT_WAKE_BIT] = |(hitV & lineEn_q & ~flagsV);
      statEvt[kli_pkg::STAT_KEY_BIT]  = |(hitV & lineEn_q & ~flagsV) & globalEn_q;
      status_d   = status_q;
      case (wrSel)
         kli_pkg::SEL_LEVEL:  begin
            levelSel_d = regWrData[N-1:0];
         end
         kli_pkg::SEL_ENABLE: begin
            lineEn_d = regWrData[N-1:0];
         end
         kli_pkg::SEL_CTRL:   begin
            globalEn_d = regWrData[kli_pkg::CTRL_GLOBAL_BIT];
         end
         kli_pkg::SEL_STATUS: begin
            status_d = status_q & ~regWrData[S-1:0];
         end
         kli_pkg::SEL_MASK:   begin
            mask_d = regWrData[S-1:0];
         end
         default: begin
            levelSel_d = levelSel_q;
         end
      endcase
      // new events win over a write-one clear
      status_d = status_d | statEvt;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         levelSel_q <= kli_pkg::RESET_BYTE[N-1:0];
         lineEn_q   <= kli_pkg::RESET_BYTE[N-1:0];
         globalEn_q <= 1'b0;
         status_q   <= '0;
         mask_q     <= '0;
      end else begin
         levelSel_q <= levelSel_d;
         lineEn_q   <= lineEn_d;
         globalEn_q <= globalEn_d;
         status_q   <= status_d;
         mask_q     <= mask_d;
      end
   end

   // ----------------------------------------------------------------
   // read data and request outputs
   // ----------------------------------------------------------------
   always_comb begin
      rdData_d = kli_pkg::RESET_BYTE;
      case (rdSel)
         kli_pkg::SEL_LEVEL:  begin
            rdData_d = 8'(levelSel_q);
         end
         kli_pkg::SEL_ENABLE: begin
            rdData_d = 8'(lineEn_q);
         end
         kli_pkg::SEL_FLAGS:  begin
            rdData_d = 8'(flagsV);
         end
         kli_pkg::SEL_CTRL:   begin
            rdData_d[kli_pkg::CTRL_GLOBAL_BIT] = globalEn_q;
         end
         kli_pkg::SEL_STATUS: begin
            rdData_d = 8'(status_q);
         end
         kli_pkg::SEL_MASK:   begin
            rdData_d = 8'(mask_q);
         end
         default: begin
            rdData_d = kli_pkg::RESET_BYTE;
         end
      endcase
      keyIrq_d = globalEn_q & |(flagsV & lineEn_q);
      wake_d   = |(flagsV & lineEn_q);
      irq_d    = |(status_q & mask_q);
   end

   always_ff @(posedge core_clk) begin
      wasReset_q <= ~reset_n;
      if (!reset_n) begin
         rdData_q <= kli_pkg::RESET_BYTE;
         keyIrq_q <= 1'b0;
         wake_q   <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         rdData_q <= rdData_d;
         keyIrq_q <= keyIrq_d;
         wake_q   <= wake_d;
         irq_q    <= irq_d;
      end
   end

   assign regRdData = rdData_q;
   assign keyLineEn = lineEn_q;
   assign keyIrqReq = keyIrq_q;
   assign wakeReq   = wake_q;
   assign irq       = irq_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence seqFlagRead;
      regRdStb && (regAddr == kli_pkg::ADDR_LINE_FLAGS);
   endsequence

   sequence seqFlagWrite;
      regWrStb && (regAddr == kli_pkg::ADDR_LINE_FLAGS);
   endsequence

   sequence seqEnabledFlag;
      (flagsV & lineEn_q) != '0;
   endsequence

   chk_flag_set_hit: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (hitV != '0) |=> ((flagsV & $past(hitV)) == $past(hitV)))
      else $error("detected line did not set its flag");

   chk_flag_sticky: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      !(regRdStb && (regAddr == kli_pkg::ADDR_LINE_FLAGS)) |=>
         ((flagsV & $past(flagsV)) == $past(flagsV)))
      else $error("flag dropped without a read");

   chk_flag_cause: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (hitV == '0) |=> ((flagsV & ~$past(flagsV)) == '0))
      else $error("flag set without a detection");

   chk_flag_write_ign: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      seqFlagWrite ##0 (hitV == '0) |=> (flagsV == $past(flagsV)))
      else $error("write changed the flag register");

   chk_read_then_clear: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      seqFlagRead |=> (regRdData == 8'($past(flagsV))) && (flagsV == $past(hitV)))
      else $error("flag read did not return then clear");

   chk_disabled_quiet: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (lineEn_q == '0) [*2] |-> !keyIrqReq && !wakeReq)
      else $error("request raised with all lines disabled");

   chk_line_gate: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      ((flagsV & lineEn_q) == '0) |=> !keyIrqReq && !wakeReq)
      else $error("request from a disabled or clear line");

   chk_enabled_request: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      seqEnabledFlag ##0 globalEn_q |=> keyIrqReq)
      else $error("enabled flag raised no request");

   chk_enable_write: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      regWrStb && (regAddr == kli_pkg::ADDR_LINE_EN) |=> (keyLineEn == $past(regWrData)))
      else $error("line enable write not taken");

   chk_global_gate: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      !globalEn_q [*2] |-> !keyIrqReq)
      else $error("request with global enable off");

   chk_reset_clear: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      wasReset_q |-> (flagsV == '0) && (lineEn_q == '0) && !keyIrqReq)
      else $error("state not cleared by reset");

   chk_level_select: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (lineLvl[0] == levelSel_q[0]) |=> flagsV[0])
      else $error("programmed level not detected");

   chk_wake_req: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      seqEnabledFlag |=> wakeReq)
      else $error("enabled flag raised no wake request");

   chk_set_wins: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      seqFlagRead ##0 (hitV != '0) |=> ((flagsV & $past(hitV)) == $past(hitV)))
      else $error("detection lost to read clear");

   chk_flag_source: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      keyIrqReq |-> $past(globalEn_q) && (($past(flagsV) & $past(lineEn_q)) != '0))
      else $error("request without enabled flag");

endmodule

// ==== bench/kli_keypad_model.sv ====
`timescale 1ns/1ps
module kli_keypad_model (
   // clock
   input  wire logic       core_clk,
   // key contacts, one bit a line, and contact speed
   input  wire logic [7:0] pressed,
   input  wire logic       slow,
   // port lines
   output logic      [7:0] portLine
);
   logic [7:0] contact_q;

   // a slow contact closes one cycle late; pull-ups hold open lines high
   always_ff @(posedge core_clk) begin
      contact_q <= pressed;
   end
   assign portLine = ~(slow ? contact_q : pressed);
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic       core_clk, reset_n, regWrStb, regRdStb, slow, rdPend;
   logic       keyIrqReq, wakeReq, irq;
   logic [7:0] regAddr, regWrData, regRdData, portIn, keyLineEn, pressed, mask;
   logic [7:0] expQ[$];
   logic [7:0] regs[6];
   int         err_count, checked;

   kli_keypad_lines dut (
      .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .portIn(portIn), .keyLineEn(keyLineEn),
      .keyIrqReq(keyIrqReq), .wakeReq(wakeReq), .irq(irq));

   kli_keypad_model pad (
      .core_clk(core_clk), .pressed(pressed), .slow(slow), .portLine(portIn));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("counts: %0d compared, %0d mismatched", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // read data checker: pops the oldest note a cycle after each read
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (rdPend) begin
         if (expQ.size() == 0) begin
            err_count++;
            $display("unexpected %0t: read with no note", $time);
         end else begin
            check(regRdData, expQ.pop_front(), "read data");
         end
      end
      rdPend = regRdStb;
   end

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrStb  <= 1'b1;
      @(posedge core_clk);
      regWrStb  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      @(posedge core_clk);
      regAddr  <= a;
      regRdStb <= 1'b1;
      @(posedge core_clk);
      regRdStb <= 1'b0;
   endtask

   task automatic outs(input logic [7:0] en, input logic ki, input logic wk, input logic iq);
      @(negedge core_clk);
      check(keyLineEn, en, "line enables");
      check({7'h00, keyIrqReq}, {7'h00, ki}, "key request");
      check({7'h00, wakeReq}, {7'h00, wk}, "wake request");
      check({7'h00, irq}, {7'h00, iq}, "irq");
      @(posedge core_clk);
   endtask

   initial begin
      repeat (4000) @(posedge core_clk);
      err_count++;
      $display("unexpected %0t: run did not finish", $time);
      give_verdict();
   end

   initial begin
      reset_n = 1'b0; regAddr = 8'h00; regWrData = 8'h00; regWrStb = 1'b0;
      regRdStb = 1'b0; pressed = 8'h00; slow = 1'b0; rdPend = 1'b0;
      err_count = 0; checked = 0;
      regs = '{kli_pkg::ADDR_LEVEL_SEL, kli_pkg::ADDR_LINE_EN, kli_pkg::ADDR_LINE_FLAGS,
               kli_pkg::ADDR_CTRL, kli_pkg::ADDR_STATUS, kli_pkg::ADDR_MASK};
      mask = 8'($urandom(84));
      idle(10);
      reset_n <= 1'b1;
      foreach (regs[i]) rd(regs[i], 8'h00);
      rd(8'h55, 8'h00);
      wr(kli_pkg::ADDR_LINE_FLAGS, 8'hFF);
      rd(kli_pkg::ADDR_LINE_FLAGS, 8'h00);
      outs(8'h00, 1'b0, 1'b0, 1'b0);
      $display("test reset and read-only done");
      // sticky flags cleared by a read
      mask  = 8'($urandom) | 8'h01;
      slow  <= 1'($urandom);
      pressed <= mask;
      idle(10);
      pressed <= 8'h00;
      idle(10);
      outs(8'h00, 1'b0, 1'b0, 1'b0);
      rd(kli_pkg::ADDR_LINE_FLAGS, mask);
      rd(kli_pkg::ADDR_LINE_FLAGS, 8'h00);
      $display("test sticky flags done");
      // high level select, detection beside a read
      wr(kli_pkg::ADDR_LEVEL_SEL, 8'h81);
      idle(8);
      rd(kli_pkg::ADDR_LEVEL_SEL, 8'h81);
      rd(kli_pkg::ADDR_LINE_FLAGS, 8'h81);
      rd(kli_pkg::ADDR_LINE_FLAGS, 8'h81);
      wr(kli_pkg::ADDR_LEVEL_SEL, 8'h00);
      idle(8);
      rd(kli_pkg::ADDR_LINE_FLAGS, 8'h81);
      rd(kli_pkg::ADDR_LINE_FLAGS, 8'h00);
      $display("test level select done");
      wr(kli_pkg::ADDR_MASK, 8'h03);
      wr(kli_pkg::ADDR_LINE_EN, 8'h04);
      pressed <= 8'h08;
      idle(10);
      outs(8'h04, 1'b0, 1'b0, 1'b0);
      pressed <= 8'h04;
      idle(10);
      outs(8'h04, 1'b0, 1'b1, 1'b1);
      rd(kli_pkg::ADDR_STATUS, 8'h02);
      wr(kli_pkg::ADDR_CTRL, 8'h01);
      idle(3);
      outs(8'h04, 1'b1, 1'b1, 1'b1);
      wr(kli_pkg::ADDR_STATUS, 8'h02);
      idle(3);
      outs(8'h04, 1'b1, 1'b1, 1'b0);
      pressed <= 8'h00;
      idle(8);
      rd(kli_pkg::ADDR_LINE_FLAGS, 8'h0C);
      idle(3);
      outs(8'h04, 1'b0, 1'b0, 1'b0);
      pressed <= 8'h04;
      idle(10);
      rd(kli_pkg::ADDR_STATUS, 8'h03);
      wr(kli_pkg::ADDR_MASK, 8'h00);
      idle(3);
      outs(8'h04, 1'b1, 1'b1, 1'b0);
      wr(kli_pkg::ADDR_STATUS, 8'h03);
      wr(kli_pkg::ADDR_MASK, 8'h03);
      idle(3);
      outs(8'h04, 1'b1, 1'b1, 1'b0);
      rd(kli_pkg::ADDR_MASK, 8'h03);
      pressed <= 8'h00;
      idle(8);
      rd(kli_pkg::ADDR_LINE_FLAGS, 8'h04);
      rd(kli_pkg::ADDR_LINE_FLAGS, 8'h00);
      $display("test request gating done");
      reset_n <= 1'b0;
      idle(5);
      reset_n <= 1'b1;
      outs(8'h00, 1'b0, 1'b0, 1'b0);
      rd(kli_pkg::ADDR_LINE_EN, 8'h00);
      rd(kli_pkg::ADDR_CTRL, 8'h00);
      $display("test mid-run reset done");
      idle(3);
      if (expQ.size() != 0) begin
         err_count++;
         $display("unexpected %0t: reads left unanswered", $time);
      end
      give_verdict();
   end
endmodule
